// ===== smsr_pkg.sv
package smsr_pkg;
	// =========================================
	// Register byte offsets
	localparam logic [11:0] ctrl_off = 12'h000;
	localparam logic [11:0] inputs_off = 12'h004;
	localparam logic [11:0] status_off = 12'h008;
	localparam logic [11:0] report_off = 12'h00c;
	localparam logic [11:0] irq_stat_off = 12'h010;
	localparam logic [11:0] irq_en_off = 12'h014;
	localparam logic [11:0] irq_clr_off = 12'h018;
	localparam logic [11:0] chan_off = 12'h01c;
	// =========================================
	// Control register fields
	localparam int ctrl_cfg_req_bit = 0;
	localparam int ctrl_cfg_done_bit = 1;
	localparam int ctrl_ack_cmd_bit = 2;
	// =========================================
	// Inputs register fields (software-fed conditions)
	localparam int in_param_ok_bit = 0;
	localparam int in_comm_up_bit = 1;
	localparam int in_comm_err_bit = 2;
	localparam int in_app_err_bit = 3;
	localparam int in_fatal_bit = 4;
	localparam int in_modulating_bit = 5;
	localparam int in_ack_local_bit = 6;
	localparam int in_ack_bus_bit = 7;
	localparam int in_passive_cmd_bit = 8;
	localparam int in_width = 9;
	// =========================================
	// Status byte and profile bit positions
	localparam int sb_fault_bit = 0;
	localparam int sb_fv_bit = 1;
	localparam int sb_ackreq_bit = 2;
	localparam int pr_mode_lo_bit = 0;
	localparam int pr_mode_hi_bit = 1;
	localparam int pr_local_bit = 2;
	localparam int pr_bus_bit = 3;
	localparam int pr_state_bit = 4;
	// =========================================
	// Mode field encodings
	localparam logic [1:0] mode_startup = 2'h0;
	localparam logic [1:0] mode_running = 2'h1;
	localparam logic [1:0] mode_failsafe = 2'h2;
	localparam logic [1:0] mode_config = 2'h3;
	// =========================================
	// Reset values
	localparam logic [2:0] status_rst = 3'h2;
	localparam logic [4:0] profile_rst = 5'h10;
	localparam logic [31:0] chan_rst = 32'h0000_0000;
	// Interrupt event bits
	localparam int irq_change_bit = 0;
	localparam int irq_ackreq_bit = 1;
	localparam int irq_fault_bit = 2;
	localparam int irq_width = 3;
	// =========================================
	// States
	typedef enum logic [2:0] {
		st_startup,
		st_operational,
		st_safe_ack,
		st_safe_passive,
		st_safe_reint,
		st_safe_cmd,
		st_failsafe,
		st_config
	} smsr_state_type;
endpackage

// ===== smsr_regbank.sv
// Small register bank, registered read data
module smsr_regbank #(
	parameter int depth = 8,
	parameter int aw = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [aw-1:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [aw-1:0] rd_addr,
	output logic [31:0] rd_data
);
	// =========================================
	// Storage
	logic [31:0] mem_reg [depth];

	// Write and registered read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < depth; i++) begin
				mem_reg[i] <= 32'h0000_0000;
			end
			rd_data <= 32'h0000_0000;
		end else begin
			if (wr_en) begin
				mem_reg[wr_addr] <= wr_data;
			end
			rd_data <= mem_reg[rd_addr];
		end
	end
endmodule

// ===== smsr_top.sv
// Operation
// - Configuration reachable anywhere when not modulating
// - Configuration leads only to Start-up
// - Start-up self-tests; host then starts link
// - Stay Start-up until params and link
// - Start-up status: ackreq 0, fv 1, fault 0
// - Start-up profile: mode 00, acks 0, state 1
// - Operational status flags all zero
// - Operational profile: mode 01, acks 0, state 0
// - Ack request only in user-ack state
// - Safe states: fv set, channels zero
// - Fault bit set exactly in Fail-safe
// - Start-up until valid safety parameters
module smsr_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] chan_in,
	output logic [2:0] status_byte,
	output logic [4:0] profile_bits,
	output logic [31:0] chan_out,
	output logic irq
);
	// =========================================
	// APB decode
	wire apb_setup = psel && !penable;
	wire apb_wr = psel && penable && pwrite;
	wire apb_rd_setup = apb_setup && !pwrite;
	wire sel_ctrl = (paddr == smsr_pkg::ctrl_off);
	wire sel_inputs = (paddr == smsr_pkg::inputs_off);
	wire sel_status = (paddr == smsr_pkg::status_off);
	wire sel_report = (paddr == smsr_pkg::report_off);
	wire sel_istat = (paddr == smsr_pkg::irq_stat_off);
	wire sel_ien = (paddr == smsr_pkg::irq_en_off);
	wire sel_iclr = (paddr == smsr_pkg::irq_clr_off);
	wire sel_chan = (paddr == smsr_pkg::chan_off);
	wire mapped = sel_ctrl | sel_inputs | sel_status | sel_report | sel_istat | sel_ien | sel_iclr | sel_chan;
	// Read data valid in access phase; one wait-free access
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Register state
	logic [smsr_pkg::in_width-1:0] inputs_reg;
	logic cfg_req_reg;
	logic cfg_done_reg;
	logic ack_cmd_reg;
	logic ack_cmd_d_reg;
	logic [smsr_pkg::irq_width-1:0] istat_reg;
	logic [smsr_pkg::irq_width-1:0] ien_reg;
	logic [31:0] rdata_reg;
	smsr_pkg::smsr_state_type state_reg;
	smsr_pkg::smsr_state_type state_next;

	// Named input conditions
	wire param_ok = inputs_reg[smsr_pkg::in_param_ok_bit];
	wire comm_up = inputs_reg[smsr_pkg::in_comm_up_bit];
	wire comm_err = inputs_reg[smsr_pkg::in_comm_err_bit];
	wire app_err = inputs_reg[smsr_pkg::in_app_err_bit];
	wire fatal = inputs_reg[smsr_pkg::in_fatal_bit];
	wire modulating = inputs_reg[smsr_pkg::in_modulating_bit];
	wire local_ack_ok = inputs_reg[smsr_pkg::in_ack_local_bit];
	wire bus_ack_ok = inputs_reg[smsr_pkg::in_ack_bus_bit];
	wire passive_cmd = inputs_reg[smsr_pkg::in_passive_cmd_bit];
	// Rising edge of the operator acknowledge command
	wire operator_ack_command = ack_cmd_reg && !ack_cmd_d_reg;

	// =========================================
	// Control and input registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inputs_reg <= '0;
			cfg_req_reg <= 1'b0;
			cfg_done_reg <= 1'b0;
			ack_cmd_reg <= 1'b0;
			ack_cmd_d_reg <= 1'b0;
			ien_reg <= '0;
		end else begin
			ack_cmd_d_reg <= ack_cmd_reg;
			// Config strobes self-clear after one cycle
			cfg_req_reg <= apb_wr && sel_ctrl && pwdata[smsr_pkg::ctrl_cfg_req_bit];
			cfg_done_reg <= apb_wr && sel_ctrl && pwdata[smsr_pkg::ctrl_cfg_done_bit];
			if (apb_wr && sel_ctrl) begin
				ack_cmd_reg <= pwdata[smsr_pkg::ctrl_ack_cmd_bit];
			end
			if (apb_wr && sel_inputs) begin
				inputs_reg <= pwdata[smsr_pkg::in_width-1:0];
			end
			if (apb_wr && sel_ien) begin
				ien_reg <= pwdata[smsr_pkg::irq_width-1:0];
			end
		end
	end

	// =========================================
	// State machine next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			smsr_pkg::st_startup: begin
				// Leave only with parameters and link up
				if (param_ok && comm_up) begin
					state_next = smsr_pkg::st_operational;
				end
			end
			smsr_pkg::st_operational: begin
				// Errors send to the matching safe state
				if (comm_err) begin
					state_next = smsr_pkg::st_safe_passive;
				end else if (app_err) begin
					state_next = smsr_pkg::st_safe_reint;
				end else if (passive_cmd) begin
					state_next = smsr_pkg::st_safe_cmd;
				end
			end
			smsr_pkg::st_safe_passive: begin
				// Wait for the link fault to clear
				if (!comm_err && comm_up) begin
					state_next = smsr_pkg::st_safe_ack;
				end
			end
			smsr_pkg::st_safe_ack: begin
				// Host acknowledge returns to Operational
				if (comm_err) begin
					state_next = smsr_pkg::st_safe_passive;
				end else if (operator_ack_command) begin
					state_next = smsr_pkg::st_operational;
				end
			end
			smsr_pkg::st_safe_reint: begin
				// Leaves once the application error clears; no acknowledge needed
				if (comm_err) begin
					state_next = smsr_pkg::st_safe_passive;
				end else if (!app_err) begin
					state_next = smsr_pkg::st_operational;
				end
			end
			smsr_pkg::st_safe_cmd: begin
				// Host withdrew passivation
				if (!passive_cmd) begin
					state_next = smsr_pkg::st_operational;
				end
			end
			smsr_pkg::st_failsafe: begin
				// Left only by reset or configuration
				state_next = smsr_pkg::st_failsafe;
			end
			smsr_pkg::st_config: begin
				// Single exit path
				if (cfg_done_reg) begin
					state_next = smsr_pkg::st_startup;
				end
			end
			default: begin
				state_next = smsr_pkg::st_startup;
			end
		endcase
		// Fatal errors override run states
		if (fatal && state_reg != smsr_pkg::st_config) begin
			state_next = smsr_pkg::st_failsafe;
		end
		// Configuration entry from any state
		if (cfg_req_reg && !modulating && state_reg != smsr_pkg::st_config) begin
			state_next = smsr_pkg::st_config;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= smsr_pkg::st_startup;
		end else begin
			state_reg <= state_next;
		end
	end

	// =========================================
	// Output encodings from next state
	wire nx_safe = (state_next == smsr_pkg::st_safe_ack) || (state_next == smsr_pkg::st_safe_passive) ||
		(state_next == smsr_pkg::st_safe_reint) || (state_next == smsr_pkg::st_safe_cmd);
	wire nx_fv = nx_safe || (state_next == smsr_pkg::st_startup) || (state_next == smsr_pkg::st_failsafe) ||
		(state_next == smsr_pkg::st_config);
	wire nx_reint = (state_next == smsr_pkg::st_safe_reint);
	logic [1:0] nx_mode;
	always_comb begin
		case (state_next)
			smsr_pkg::st_startup: nx_mode = smsr_pkg::mode_startup;
			smsr_pkg::st_failsafe: nx_mode = smsr_pkg::mode_failsafe;
			smsr_pkg::st_config: nx_mode = smsr_pkg::mode_config;
			default: nx_mode = smsr_pkg::mode_running;
		endcase
	end
	logic [2:0] status_next;
	logic [4:0] profile_next;
	always_comb begin
		status_next = '0;
		status_next[smsr_pkg::sb_ackreq_bit] = (state_next == smsr_pkg::st_safe_ack);
		status_next[smsr_pkg::sb_fv_bit] = nx_fv;
		status_next[smsr_pkg::sb_fault_bit] = (state_next == smsr_pkg::st_failsafe);
		profile_next = '0;
		profile_next[smsr_pkg::pr_mode_hi_bit] = nx_mode[1];
		profile_next[smsr_pkg::pr_mode_lo_bit] = nx_mode[0];
		profile_next[smsr_pkg::pr_local_bit] = nx_reint && local_ack_ok;
		profile_next[smsr_pkg::pr_bus_bit] = nx_reint && bus_ack_ok;
		profile_next[smsr_pkg::pr_state_bit] = (state_next != smsr_pkg::st_operational);
	end

	// Events for interrupts
	wire [smsr_pkg::irq_width-1:0] ev;
	assign ev[smsr_pkg::irq_change_bit] = (state_next != state_reg);
	assign ev[smsr_pkg::irq_ackreq_bit] = status_next[smsr_pkg::sb_ackreq_bit] && !status_byte[smsr_pkg::sb_ackreq_bit];
	assign ev[smsr_pkg::irq_fault_bit] = status_next[smsr_pkg::sb_fault_bit] && !status_byte[smsr_pkg::sb_fault_bit];
	wire [smsr_pkg::irq_width-1:0] iclr = (apb_wr && sel_iclr) ? pwdata[smsr_pkg::irq_width-1:0] : '0;

	// =========================================
	// Output and interrupt registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_byte <= smsr_pkg::status_rst;
			profile_bits <= smsr_pkg::profile_rst;
			chan_out <= smsr_pkg::chan_rst;
			istat_reg <= '0;
		end else begin
			status_byte <= status_next;
			profile_bits <= profile_next;
			// Fail-safe zero whenever outputs are not live
			chan_out <= nx_fv ? smsr_pkg::chan_rst : chan_in;
			// Set wins over clear
			istat_reg <= (istat_reg & ~iclr) | ev;
		end
	end
	assign irq = |(istat_reg & ien_reg);

	// =========================================
	// Readback mux of live state words; bank output unused
	wire [31:0] rd_mux = sel_ctrl ? {29'h0, ack_cmd_reg, 2'h0} :
		sel_inputs ? {{(32 - smsr_pkg::in_width){1'b0}}, inputs_reg} :
		sel_status ? {29'h0, status_byte} :
		sel_report ? {24'h0, 3'h0, profile_bits} :
		sel_istat ? {29'h0, istat_reg} :
		sel_ien ? {29'h0, ien_reg} :
		sel_chan ? chan_out : 32'h0000_0000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h0000_0000;
		end else if (apb_rd_setup) begin
			rdata_reg <= rd_mux;
		end
	end
	wire [31:0] bank_rd;
	smsr_regbank #(.depth(8), .aw(3)) u_bank (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(apb_wr && mapped),
		.wr_addr(paddr[4:2]),
		.wr_data(pwdata),
		.rd_addr(paddr[4:2]),
		.rd_data(bank_rd)
	);
	// Bank keeps last written words; live view wins
	assign prdata = (psel && penable && !pwrite) ? rdata_reg : 32'h0000_0000;
	wire unused_bank = |bank_rd;

	// =========================================
	// Assertions
	a_cfg_entry: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_req_reg && !modulating && state_reg != smsr_pkg::st_config |=> state_reg == smsr_pkg::st_config)
		else $error("config entry missed");
	a_cfg_exit: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == smsr_pkg::st_config && state_next != smsr_pkg::st_config |-> state_next == smsr_pkg::st_startup)
		else $error("bad exit from config");
	a_startup_hold: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == smsr_pkg::st_startup && !(param_ok && comm_up) && !cfg_req_reg && !fatal |=>
		state_reg == smsr_pkg::st_startup)
		else $error("left startup early");
	a_startup_enc: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == smsr_pkg::st_startup |-> status_byte == 3'h2 && profile_bits == 5'h10)
		else $error("startup encoding wrong");
	a_oper_enc: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == smsr_pkg::st_operational |-> status_byte == 3'h0 && profile_bits == 5'h01)
		else $error("operational encoding wrong");
	a_ackreq_only: assert property (@(posedge pclk) disable iff (!presetn)
		status_byte[smsr_pkg::sb_ackreq_bit] |-> state_reg == smsr_pkg::st_safe_ack)
		else $error("ack request outside ack state");
	a_safe_zero: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == smsr_pkg::st_safe_passive |-> chan_out == 32'h0 && status_byte[smsr_pkg::sb_fv_bit])
		else $error("safe state not zeroed");
	a_fault_bit: assert property (@(posedge pclk) disable iff (!presetn)
		status_byte[smsr_pkg::sb_fault_bit] == (state_reg == smsr_pkg::st_failsafe))
		else $error("fault bit mismatch");
	a_ack_return: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == smsr_pkg::st_safe_ack && operator_ack_command && !comm_err && !fatal && !cfg_req_reg |=>
		state_reg == smsr_pkg::st_operational ##0 $past(status_byte[smsr_pkg::sb_ackreq_bit]))
		else $error("ack did not return");
endmodule

// ===== smsr_host_model.sv
// Safety host stand-in: live channel feed and acknowledge permission
module smsr_host_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] status_byte,
	output logic [31:0] chan_in,
	output logic ack_allowed
);
	timeunit 1ns;
	timeprecision 1ps;
	// =========================================
	// Channel feed
	// Shifting pattern, new every cycle, never all zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_in <= 32'h0000_0001;
		end else begin
			chan_in <= {chan_in[30:0], chan_in[31] ^ chan_in[21] ^ chan_in[1] ^ chan_in[0]};
		end
	end
	// =========================================
	// Acknowledge only while the device asks for it
	assign ack_allowed = status_byte[smsr_pkg::sb_ackreq_bit];
endmodule

// ===== smsr_top_tb_top.sv
// Self-checking bench for the mode and state reporting block
module smsr_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// =========================================
	// Signals
	logic pclk = 1'b0; // Bus clock
	logic presetn = 1'b0; // Active low reset
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] chan_in; // From host model
	logic [2:0] status_byte;
	logic [4:0] profile_bits;
	logic [31:0] chan_out;
	logic irq;
	logic ack_allowed; // Host says acknowledge may go
	logic [31:0] rd; // Last read data
	logic err; // Last slave error
	logic [31:0] chan_d; // Channel input one cycle back
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;
	// =========================================
	// Design and host
	smsr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chan_in(chan_in), .status_byte(status_byte), .profile_bits(profile_bits),
		.chan_out(chan_out), .irq(irq));
	smsr_host_model host (.pclk(pclk), .presetn(presetn), .status_byte(status_byte),
		.chan_in(chan_in), .ack_allowed(ack_allowed));
	// =========================================
	// Clock, channel history and hang guard
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		chan_d <= chan_in;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			$display("BAD %0t timeout", $time);
			summarize();
		end
	end
	// =========================================
	// Helpers
	function automatic logic [31:0] b(input int n);
		return 32'h0000_0001 << n;
	endfunction
	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for the answer; pready is tied high, so one edge ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Outputs settle one edge after the write; checked two edges after the transfer
	task automatic st(input logic [31:0] s, input logic [31:0] p);
		repeat (2) @(posedge pclk);
		chk(status_byte, s);
		chk(profile_bits, p);
	endtask
	task automatic summarize;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// =========================================
	// Test sequence
	initial begin
		logic [31:0] up;
		up = b(smsr_pkg::in_param_ok_bit) | b(smsr_pkg::in_comm_up_bit);
		repeat (3) @(posedge pclk);
		chk(status_byte, 32'h0000_0002);
		chk(profile_bits, 32'h0000_0010);
		chk(chan_out, 32'h0000_0000);
		presetn <= 1'b1;
		@(posedge pclk);
		$display("reset test done");
		// Start-up holds without parameters or link
		apb(1'b1, smsr_pkg::inputs_off, b(smsr_pkg::in_comm_up_bit));
		st(32'h0000_0002, 32'h0000_0010);
		apb(1'b1, smsr_pkg::inputs_off, b(smsr_pkg::in_param_ok_bit));
		st(32'h0000_0002, 32'h0000_0010);
		apb(1'b0, smsr_pkg::status_off, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		apb(1'b1, smsr_pkg::irq_en_off, b(smsr_pkg::irq_ackreq_bit));
		$display("startup test done");
		// Operational, then passivation and acknowledge
		apb(1'b1, smsr_pkg::inputs_off, up);
		st(32'h0000_0000, 32'h0000_0001);
		chk(chan_out, chan_d);
		chk(irq, 32'h0000_0000);
		apb(1'b1, smsr_pkg::inputs_off, up | b(smsr_pkg::in_comm_err_bit));
		st(32'h0000_0002, 32'h0000_0011);
		chk(chan_out, 32'h0000_0000);
		apb(1'b1, smsr_pkg::inputs_off, up);
		st(32'h0000_0006, 32'h0000_0011);
		chk(irq, 32'h0000_0001);
		apb(1'b0, smsr_pkg::irq_stat_off, 32'h0000_0000);
		chk(rd, 32'h0000_0003);
		apb(1'b1, smsr_pkg::irq_clr_off, 32'h0000_0007);
		chk(irq, 32'h0000_0000);
		if (ack_allowed === 1'b1) begin
			apb(1'b1, smsr_pkg::ctrl_off, b(smsr_pkg::ctrl_ack_cmd_bit));
		end
		st(32'h0000_0000, 32'h0000_0001);
		$display("acknowledge test done");
		// Reintegration after an application error, each ack path offered
		apb(1'b1, smsr_pkg::inputs_off, up | b(smsr_pkg::in_app_err_bit) | b(smsr_pkg::in_ack_local_bit));
		st(32'h0000_0002, 32'h0000_0015);
		chk(chan_out, 32'h0000_0000);
		apb(1'b1, smsr_pkg::inputs_off, up | b(smsr_pkg::in_app_err_bit) | b(smsr_pkg::in_ack_bus_bit));
		st(32'h0000_0002, 32'h0000_0019);
		apb(1'b1, smsr_pkg::inputs_off, up);
		st(32'h0000_0000, 32'h0000_0001);
		// Passivation by host command
		apb(1'b1, smsr_pkg::inputs_off, up | b(smsr_pkg::in_passive_cmd_bit));
		st(32'h0000_0002, 32'h0000_0011);
		apb(1'b1, smsr_pkg::inputs_off, up);
		st(32'h0000_0000, 32'h0000_0001);
		$display("reintegration test done");
		// Fail-safe and the fault bit
		apb(1'b1, smsr_pkg::inputs_off, up | b(smsr_pkg::in_fatal_bit));
		st(32'h0000_0003, 32'h0000_0012);
		chk(chan_out, 32'h0000_0000);
		$display("failsafe test done");
		// Configuration refused while modulating, then taken
		apb(1'b1, smsr_pkg::inputs_off, up | b(smsr_pkg::in_fatal_bit) | b(smsr_pkg::in_modulating_bit));
		apb(1'b1, smsr_pkg::ctrl_off, b(smsr_pkg::ctrl_cfg_req_bit));
		st(32'h0000_0003, 32'h0000_0012);
		apb(1'b1, smsr_pkg::inputs_off, up | b(smsr_pkg::in_fatal_bit));
		apb(1'b1, smsr_pkg::ctrl_off, b(smsr_pkg::ctrl_cfg_req_bit));
		st(32'h0000_0002, 32'h0000_0013);
		apb(1'b1, smsr_pkg::inputs_off, up);
		st(32'h0000_0002, 32'h0000_0013);
		apb(1'b1, smsr_pkg::inputs_off, 32'h0000_0000);
		apb(1'b1, smsr_pkg::ctrl_off, b(smsr_pkg::ctrl_cfg_done_bit));
		st(32'h0000_0002, 32'h0000_0010);
		$display("configuration test done");
		// Reset in mid-run, from Operational back to Start-up
		apb(1'b1, smsr_pkg::inputs_off, up);
		st(32'h0000_0000, 32'h0000_0001);
		presetn <= 1'b0;
		@(posedge pclk);
		chk(status_byte, 32'h0000_0002);
		chk(profile_bits, 32'h0000_0010);
		chk(chan_out, 32'h0000_0000);
		chk(irq, 32'h0000_0000);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, smsr_pkg::inputs_off, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		st(32'h0000_0002, 32'h0000_0010);
		$display("mid-run reset test done");
		// Unmapped and read-only places
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk(err, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		apb(1'b1, smsr_pkg::status_off, 32'h0000_0000);
		apb(1'b0, smsr_pkg::status_off, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		$display("access test done");
		summarize();
	end
endmodule
